// ---- accumulator_or_unit.sv ----
// accumulator or unit: word, double and bitrange or with status flags
`timescale 1ns/10ps
module accumulator_or_unit (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // instruction request
  input wire logic op_valid_i,
  input wire logic [1:0] op_code_i,
  input wire logic op_use_imm_i,
  input wire logic [or_unit_pkg::MEM_AW-1:0] op_addr_i,
  input wire logic [or_unit_pkg::BIT_AW-1:0] op_bit_addr_i,
  input wire logic [or_unit_pkg::CNT_W-1:0] op_count_i,
  input wire logic [or_unit_pkg::ACC_W-1:0] op_imm_i,
  output logic op_ready_o,
  output logic op_done_o,
  // accumulator load from sequencer
  input wire logic acc_load_i,
  input wire logic [or_unit_pkg::ACC_W-1:0] acc_load_data_i,
  // data memory word read
  output logic mem_rd_o,
  output logic [or_unit_pkg::MEM_AW-1:0] mem_addr_o,
  input wire logic [or_unit_pkg::WORD_W-1:0] mem_rdata_i,
  // discrete bit read
  output logic bit_rd_o,
  output logic [or_unit_pkg::BIT_AW-1:0] bit_addr_o,
  input wire logic bit_rdata_i,
  // results
  output logic [or_unit_pkg::ACC_W-1:0] acc_o,
  output logic zero_result_flag_o,
  output logic negative_result_flag_o
);
  logic rst_meta_r;
  logic rst_sync_r;
  or_unit_pkg::or_state_t state_r, state_nxt;
  or_unit_pkg::or_op_t op_r, op_nxt;
  logic [or_unit_pkg::CNT_W-1:0] idx_r, idx_nxt;
  logic [or_unit_pkg::CNT_W-1:0] need_r, need_nxt;
  logic [or_unit_pkg::ACC_W-1:0] opnd_r, opnd_nxt;
  logic [or_unit_pkg::ACC_W-1:0] acc_r, acc_nxt;
  logic zero_r, zero_nxt;
  logic neg_r, neg_nxt;
  logic done_r, done_nxt;
  logic mem_rd_r, mem_rd_nxt;
  logic bit_rd_r, bit_rd_nxt;
  logic [or_unit_pkg::MEM_AW-1:0] mem_addr_r, mem_addr_nxt;
  logic [or_unit_pkg::BIT_AW-1:0] bit_addr_r, bit_addr_nxt;
  logic count_ok;
  logic [or_unit_pkg::CNT_W-1:0] idx_inc;

  // request code matches operation
  function automatic logic code_is(input logic [1:0] code, input or_unit_pkg::or_op_t op);
    code_is = (code == 2'(op));
  endfunction

  // bitrange operation test
  function automatic logic is_bit_op(input or_unit_pkg::or_op_t op);
    is_bit_op = (op == or_unit_pkg::OP_OR_BITRANGE);
  endfunction

  function automatic logic count_legal(input logic [or_unit_pkg::CNT_W-1:0] cnt);
    count_legal = (cnt >= or_unit_pkg::CNT_MIN) && (cnt <= or_unit_pkg::CNT_MAX);
  endfunction

  or_calc_if calc_bus ();

  or_combiner u_combiner (
    .c(calc_bus)
  );

  // reset release synchroniser
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign calc_bus.acc = acc_r;
  assign calc_bus.opnd = opnd_r;
  assign calc_bus.op = op_r;

  // bitrange count check
  assign count_ok = count_legal(op_count_i);
  assign idx_inc = idx_r + or_unit_pkg::CNT_MIN;

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    idx_nxt = idx_r;
    need_nxt = need_r;
    opnd_nxt = opnd_r;
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    neg_nxt = neg_r;
    done_nxt = 1'b0;
    mem_rd_nxt = 1'b0;
    bit_rd_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    bit_addr_nxt = bit_addr_r;
    case (state_r)
      or_unit_pkg::ST_IDLE: begin
        if (op_valid_i) begin
          idx_nxt = '0;
          opnd_nxt = '0;
          mem_addr_nxt = op_addr_i;
          bit_addr_nxt = op_bit_addr_i;
          if (code_is(op_code_i, or_unit_pkg::OP_OR_WORD)) begin
            op_nxt = or_unit_pkg::OP_OR_WORD;
            need_nxt = or_unit_pkg::WORDS_SINGLE;
            mem_rd_nxt = 1'b1;
            state_nxt = or_unit_pkg::ST_ISSUE;
          end else if (code_is(op_code_i, or_unit_pkg::OP_OR_DOUBLE)) begin
            op_nxt = or_unit_pkg::OP_OR_DOUBLE;
            need_nxt = or_unit_pkg::WORDS_DOUBLE;
            if (op_use_imm_i) begin
              opnd_nxt = op_imm_i;
              state_nxt = or_unit_pkg::ST_FINISH;
            end else begin
              mem_rd_nxt = 1'b1;
              state_nxt = or_unit_pkg::ST_ISSUE;
            end
          end else if (code_is(op_code_i, or_unit_pkg::OP_OR_BITRANGE) && count_ok) begin
            op_nxt = or_unit_pkg::OP_OR_BITRANGE;
            need_nxt = op_count_i;
            bit_rd_nxt = 1'b1;
            state_nxt = or_unit_pkg::ST_ISSUE;
          end
        end else if (acc_load_i) begin
          acc_nxt = acc_load_data_i;
        end
      end
      or_unit_pkg::ST_ISSUE: begin
        state_nxt = or_unit_pkg::ST_CAPTURE;
      end
      or_unit_pkg::ST_CAPTURE: begin
        if (is_bit_op(op_r)) begin
          opnd_nxt[idx_r[4:0]] = bit_rdata_i;
        end else if (idx_r == '0) begin
          opnd_nxt[or_unit_pkg::WORD_W-1:0] = mem_rdata_i;
        end else begin
          opnd_nxt[or_unit_pkg::ACC_W-1:or_unit_pkg::WORD_W] = mem_rdata_i;
        end
        idx_nxt = idx_inc;
        if (idx_inc == need_r) begin
          state_nxt = or_unit_pkg::ST_FINISH;
        end else begin
          mem_addr_nxt = mem_addr_r + 16'h0001;
          bit_addr_nxt = bit_addr_r + 12'h001;
          mem_rd_nxt = !is_bit_op(op_r);
          bit_rd_nxt = is_bit_op(op_r);
          state_nxt = or_unit_pkg::ST_ISSUE;
        end
      end
      or_unit_pkg::ST_FINISH: begin
        acc_nxt = calc_bus.result;
        zero_nxt = calc_bus.zero;
        if (calc_bus.neg_upd) begin
          neg_nxt = calc_bus.neg;
        end
        done_nxt = 1'b1;
        state_nxt = or_unit_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = or_unit_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= or_unit_pkg::ST_IDLE;
      op_r <= or_unit_pkg::OP_OR_WORD;
      idx_r <= '0;
      need_r <= '0;
      opnd_r <= or_unit_pkg::ACC_RST;
      acc_r <= or_unit_pkg::ACC_RST;
      zero_r <= 1'b0;
      neg_r <= 1'b0;
      done_r <= 1'b0;
      mem_rd_r <= 1'b0;
      bit_rd_r <= 1'b0;
      mem_addr_r <= or_unit_pkg::MEM_ADDR_RST;
      bit_addr_r <= or_unit_pkg::BIT_ADDR_RST;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      need_r <= need_nxt;
      opnd_r <= opnd_nxt;
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
      neg_r <= neg_nxt;
      done_r <= done_nxt;
      mem_rd_r <= mem_rd_nxt;
      bit_rd_r <= bit_rd_nxt;
      mem_addr_r <= mem_addr_nxt;
      bit_addr_r <= bit_addr_nxt;
    end
  end

  assign op_ready_o = (state_r == or_unit_pkg::ST_IDLE);
  assign op_done_o = done_r;
  assign mem_rd_o = mem_rd_r;
  assign mem_addr_o = mem_addr_r;
  assign bit_rd_o = bit_rd_r;
  assign bit_addr_o = bit_addr_r;
  assign acc_o = acc_r;
  assign zero_result_flag_o = zero_r;
  assign negative_result_flag_o = neg_r;
endmodule

// ---- accumulator_or_unit_asserts.sv ----
// assertion checker for the accumulator or unit
`timescale 1ns/10ps
module or_unit_checker (
  // clock, reset and request
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic op_valid_i,
  input wire logic [1:0] op_code_i,
  input wire logic op_use_imm_i,
  input wire logic [15:0] op_addr_i,
  input wire logic [11:0] op_bit_addr_i,
  input wire logic [5:0] op_count_i,
  input wire logic [31:0] op_imm_i,
  // unit outputs
  input wire logic op_ready_o,
  input wire logic op_done_o,
  input wire logic mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic bit_rd_o,
  input wire logic [11:0] bit_addr_o,
  input wire logic [31:0] acc_o,
  input wire logic zero_result_flag_o,
  input wire logic negative_result_flag_o
);
  logic tk;
  assign tk = op_ready_o && op_valid_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_done_pulse: assert property (op_done_o |=> !op_done_o)
    else $error("done held beyond one cycle");
  a_word_done: assert property (tk && op_code_i == 2'h0 |-> ##4 op_done_o)
    else $error("word or done not on time");
  a_word_read: assert property (tk && op_code_i == 2'h0 |=>
    mem_rd_o && mem_addr_o == $past(op_addr_i) ##1 !mem_rd_o)
    else $error("word read strobe wrong");
  a_imm_value: assert property (tk && op_code_i == 2'h1 && op_use_imm_i |-> ##2
    op_done_o && acc_o == ($past(acc_o, 2) | $past(op_imm_i, 2)))
    else $error("double immediate result wrong");
  a_imm_neg: assert property (tk && op_code_i == 2'h1 && op_use_imm_i |-> ##2
    negative_result_flag_o == acc_o[31])
    else $error("negative flag wrong");
  a_zero_flag: assert property (op_done_o |-> zero_result_flag_o == (acc_o == 32'h0))
    else $error("zero flag wrong");
  a_flags_hold: assert property (!op_done_o |->
    $stable(zero_result_flag_o) && $stable(negative_result_flag_o))
    else $error("flags changed outside done");
  a_pair_addr: assert property (tk && op_code_i == 2'h1 && !op_use_imm_i |-> ##3
    mem_rd_o && mem_addr_o == $past(op_addr_i, 3) + 16'h1)
    else $error("second word address wrong");
  a_bit_first: assert property (tk && op_code_i == 2'h2 && op_count_i inside {[6'h01:6'h20]} |=>
    bit_rd_o && bit_addr_o == $past(op_bit_addr_i))
    else $error("first bit address wrong");
  a_busy_ready: assert property (tk && (op_code_i < 2'h2 || (op_code_i == 2'h2 && op_count_i inside {[6'h01:6'h20]}))
    |=> !op_ready_o)
    else $error("ready not low while busy");
  a_bad_code: assert property (tk && op_code_i == 2'h3 |=>
    !mem_rd_o && !bit_rd_o && op_ready_o)
    else $error("illegal code not ignored");
endmodule
bind accumulator_or_unit or_unit_checker or_unit_checker_i (.*);

// ---- or_calc_if.sv ----
// carrier between the sequencing core and the or combiner
`timescale 1ns/10ps
interface or_calc_if;
  logic [or_unit_pkg::ACC_W-1:0] acc;
  logic [or_unit_pkg::ACC_W-1:0] opnd;
  or_unit_pkg::or_op_t op;
  logic [or_unit_pkg::ACC_W-1:0] result;
  logic zero;
  logic neg;
  logic neg_upd;
  modport core (output acc, output opnd, output op, input result, input zero, input neg, input neg_upd);
  modport calc (input acc, input opnd, input op, output result, output zero, output neg, output neg_upd);
endinterface

// ---- or_combiner.sv ----
// combinational or of accumulator with operand and flag derivation
`timescale 1ns/10ps
module or_combiner (
  or_calc_if.calc c
);
  always_comb begin
    if (c.op == or_unit_pkg::OP_OR_WORD) begin
      c.result = {c.acc[or_unit_pkg::ACC_W-1:or_unit_pkg::WORD_W],
                  c.acc[or_unit_pkg::WORD_W-1:0] | c.opnd[or_unit_pkg::WORD_W-1:0]};
      c.neg_upd = 1'b0;
    end else begin
      c.result = c.acc | c.opnd;
      c.neg_upd = 1'b1;
    end
    c.zero = (c.result == '0);
    c.neg = c.result[or_unit_pkg::NEG_BIT];
  end
endmodule

// ---- or_unit_pkg.sv ----
// constants and types for the accumulator or unit
package or_unit_pkg;
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int MEM_AW = 16;
  localparam int BIT_AW = 12;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MIN = 6'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h20;
  localparam logic [CNT_W-1:0] WORDS_SINGLE = 6'h01;
  localparam logic [CNT_W-1:0] WORDS_DOUBLE = 6'h02;
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [MEM_AW-1:0] MEM_ADDR_RST = 16'h0000;
  localparam logic [BIT_AW-1:0] BIT_ADDR_RST = 12'h000;
  localparam int NEG_BIT = ACC_W - 1;

  typedef enum logic [1:0] {
    OP_OR_WORD = 2'h0,
    OP_OR_DOUBLE = 2'h1,
    OP_OR_BITRANGE = 2'h2
  } or_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ISSUE = 4'h2,
    ST_CAPTURE = 4'h4,
    ST_FINISH = 4'h8
  } or_state_t;
endpackage

// ---- test_accumulator_or_unit.sv ----
// self-checking bench for the accumulator or unit
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_accumulator_or_unit;
  logic sys_clk_i = 0, resetn_i = 0, op_valid_i = 0, op_use_imm_i = 0, acc_load_i = 0, bit_rdata_i = 0;
  logic [1:0] op_code_i = 2'h0;
  logic [15:0] op_addr_i = 16'h0000, mem_rdata_i = 16'h0000, mem_addr_o;
  logic [11:0] op_bit_addr_i = 12'h000, bit_addr_o;
  logic [5:0] op_count_i = 6'h01;
  logic [31:0] op_imm_i = 32'h0, acc_load_data_i = 32'h0, acc_o, acc_m = 32'h0, bits = 32'ha5c3_0f96;
  logic op_ready_o, op_done_o, mem_rd_o, bit_rd_o, zero_result_flag_o, negative_result_flag_o, n_m = 0, rq, bq;
  logic [15:0] mem [0:3] = '{16'h1234, 16'h0000, 16'h8001, 16'hc000};
  int fails = 0, n_checks = 0, cyc = 0;
  accumulator_or_unit accumulator_or_unit_i (.*);
  initial forever #25 sys_clk_i = ~sys_clk_i;
  // memory and bit source, one cycle after each strobe
  always @(posedge sys_clk_i) begin
    rq = mem_rd_o;
    bq = bit_rd_o;
    #1 mem_rdata_i = rq ? mem[mem_addr_o[1:0]] : ~mem_rdata_i;
    bit_rdata_i = bq ? bits[bit_addr_o[4:0]] : ~bit_rdata_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic load(input logic [31:0] v);
    acc_load_data_i = v;
    acc_load_i = 1;
    @(posedge sys_clk_i);
    #1 acc_load_i = 0;
    acc_m = v;
  endtask
  task automatic do_op(input logic [1:0] c, input logic s, input logic [15:0] a, input logic [5:0] n,
      input logic [31:0] k, input int lat, input logic [31:0] ea, input logic un);
    int t;
    t = 1;
    op_code_i = c;
    op_use_imm_i = s;
    op_addr_i = a;
    op_bit_addr_i = a[11:0];
    op_count_i = n;
    op_imm_i = k;
    op_valid_i = 1;
    @(posedge sys_clk_i);
    #1 op_valid_i = 0;
    while (op_done_o !== 1'b1 && t < 80) begin
      @(posedge sys_clk_i);
      #1 t++;
    end
    `CHK("latency", lat, t)
    `CHK("acc", ea, acc_o)
    `CHK("zero", ea == 32'h0, zero_result_flag_o)
    `CHK("neg", un ? ea[31] : n_m, negative_result_flag_o)
    acc_m = ea;
    if (un) n_m = ea[31];
  endtask
  task automatic t_reset();
    `CHK("reset", 36'h8_0000_0000, {op_ready_o, op_done_o, zero_result_flag_o, negative_result_flag_o, acc_o})
  endtask
  task automatic t_word();
    load(32'h8000_00ff);
    do_op(2'h0, 0, 16'h0000, 6'h01, 32'h0, 4, 32'h8000_12ff, 0);
    load(32'h0);
    do_op(2'h0, 0, 16'h0001, 6'h01, 32'h0, 4, 32'h0, 0);
  endtask
  task automatic t_double();
    acc_load_data_i = 32'hffff_ffff;
    acc_load_i = 1;
    do_op(2'h1, 1, 16'h0000, 6'h01, 32'h3647_6a38, 2, 32'h3647_6a38, 1);
    acc_load_i = 0;
    do_op(2'h1, 1, 16'h0000, 6'h01, 32'h8000_0000, 2, 32'hb647_6a38, 1);
    load(32'h0);
    do_op(2'h1, 1, 16'h0000, 6'h01, 32'h0, 2, 32'h0, 1);
    do_op(2'h1, 0, 16'hffff, 6'h01, 32'h0, 6, 32'h1234_c000, 1);
    do_op(2'h1, 0, 16'h0001, 6'h01, 32'h0, 6, 32'h9235_c000, 1);
  endtask
  task automatic t_bits();
    load(32'h0);
    do_op(2'h2, 0, 16'h0002, 6'h01, 32'h0, 4, 32'h1, 1);
    do_op(2'h2, 0, 16'h0004, 6'h04, 32'h0, 10, 32'h9, 1);
    do_op(2'h2, 0, 16'h0000, 6'h20, 32'h0, 66, 32'ha5c3_0f9f, 1);
  endtask
  task automatic t_refuse();
    for (int i = 0; i < 3; i++) begin
      op_code_i = i == 0 ? 2'h3 : 2'h2;
      op_count_i = i == 1 ? 6'h00 : 6'h21;
      op_valid_i = 1;
      repeat (2) @(posedge sys_clk_i);
      #1 op_valid_i = 0;
      repeat (70) begin
        @(posedge sys_clk_i);
        #1 `CHK("idle", {3'h0, acc_m}, {op_done_o, mem_rd_o, bit_rd_o, acc_o})
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    #1 resetn_i = 1;
    repeat (3) @(posedge sys_clk_i);
    #1 t_reset();
    t_word();
    t_double();
    t_bits();
    t_refuse();
    conclude();
  end
endmodule
